// [hw/adcs_top.sv]
`timescale 1ns/10ps
`include "adcs_defines.svh"

// Behaviour
// - Hold capacitor is disconnected from the pin for the whole conversion.
// - A conversion lasts exactly twelve bit periods.
// - Clock select maps to 2,4,8,16,32,64 oscillator periods or RC.
// - Channel select and pin direction never gate a conversion.
// - Port reads return zero on analog-configured pins.
// - A digital-configured pin is still converted when selected.
// - Clearing go mid-conversion aborts it; results stay unchanged.
// - After an abort wait two bit periods, then acquire again.
// - Special-event mode with power on lets the trigger start a conversion.
// - Each special event resets the associated timer.
// - With power off the trigger is ignored but the timer still resets.
// - Go starts a conversion when powered; hardware clears it on completion.
// - Completion loads result, clears go and sets the done flag.
// - Justify select places the result right or left with zero padding.
// - Reset restores control registers, powers off and aborts.

module adcs_top #(
    parameter int WIDTH = 10,
    parameter int DIV_W = 7
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:2]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rc_osc_i,
    input  wire logic        comp_i,
    input  wire logic [7:0]  port_pins_i,
    input  wire logic        special_trig_i,
    output logic [2:0]       channel_o,
    output logic             hold_connect_o,
    output logic [9:0]       dac_code_o,
    output logic             timer_reset_o
);

    if (WIDTH != 10) begin : g_chk
        $error("adcs_top: result layout serves a 10-bit converter only");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************

    adcs_pkg::adcs_state_t state_ff;
    adcs_pkg::adcs_state_t nxt_state;
    adcs_pkg::adcs_cfg_t   cfg_ff;

    logic                  power_on_ff;
    logic                  go_ff;
    logic [3:0]            compare_mode_ff;
    logic [7:0]            result_high_ff;
    logic [7:0]            result_low_ff;
    logic                  done_flag_ff;
    logic [7:0]            pin_meta_ff;
    logic [7:0]            pin_sync_ff;
    logic [1:0]            wait_cnt_ff;
    logic [7:0]            rd_byte;

    logic                  bus_req;
    logic                  wr_en;
    logic                  wr_ctrl0;
    logic                  wr_ctrl1;
    logic                  trig_hit;
    logic                  go_set;
    logic                  go_clr;
    logic                  conv_start;
    logic                  conv_abort;
    logic                  tad_tick;
    logic                  sar_done;
    logic [WIDTH-1:0]      sar_code;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Analog-function pins per port configuration, AN7..AN0, 1 = analog
    function automatic logic [7:0] analog_mask(input logic [3:0] pcfg);
        unique case (pcfg)
            4'h0, 4'h1, 4'h8:       analog_mask = 8'hff;
            4'h2, 4'h3, 4'hc:       analog_mask = 8'h1f;
            4'h4, 4'h5:             analog_mask = 8'h0b;
            4'h6, 4'h7:             analog_mask = 8'h00;
            4'h9, 4'ha, 4'hb:       analog_mask = 8'h3f;
            4'hd:                   analog_mask = 8'h0f;
            4'he:                   analog_mask = 8'h01;
            4'hf:                   analog_mask = 8'h0d;
        endcase
    endfunction

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************

    // Writes commit on the edge where the master samples ack
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign wr_en    = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign wr_ctrl0 = wr_en && (wb_adr_i == `ADCS_IDX_CTRL0);
    assign wr_ctrl1 = wr_en && (wb_adr_i == `ADCS_IDX_CTRL1);

    // Single-cycle ack, dropped the cycle after; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end

    // Read multiplexer; reserved bits read zero
    always_comb begin
        rd_byte = `ADCS_RST_BYTE;
        unique case (wb_adr_i)
            `ADCS_IDX_CTRL0: begin
                rd_byte[`ADCS_C0_PWR]  = power_on_ff;
                rd_byte[`ADCS_C0_GO]   = go_ff;
                rd_byte[`ADCS_C0_CHAN] = cfg_ff.channel;
                rd_byte[`ADCS_C0_CLK]  = cfg_ff.clk_sel[1:0];
            end
            `ADCS_IDX_CTRL1: begin
                rd_byte[`ADCS_C1_PCFG] = cfg_ff.pcfg;
                rd_byte[`ADCS_C1_CLK2] = cfg_ff.clk_sel[2];
                rd_byte[`ADCS_C1_JUST] = cfg_ff.justify;
            end
            `ADCS_IDX_RES_HI:  rd_byte = result_high_ff;
            `ADCS_IDX_RES_LO:  rd_byte = result_low_ff;
            `ADCS_IDX_STATUS:  rd_byte[`ADCS_ST_DONE] = done_flag_ff;
            `ADCS_IDX_PORT:    rd_byte = pin_sync_ff & ~analog_mask(cfg_ff.pcfg);
            `ADCS_IDX_COMPARE: rd_byte[`ADCS_CMP_MODE] = compare_mode_ff;
            default:           rd_byte = `ADCS_RST_BYTE;
        endcase
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Power bit; turning it off also clears go, which aborts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_on_ff <= 1'b0;
        end else if (wr_ctrl0) begin
            power_on_ff <= wb_dat_i[`ADCS_C0_PWR];
        end
    end

    // Configuration fields, split over the two control words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= `ADCS_RST_CFG;
        end else begin
            if (wr_ctrl0) begin
                cfg_ff.channel      <= wb_dat_i[`ADCS_C0_CHAN];
                cfg_ff.clk_sel[1:0] <= wb_dat_i[`ADCS_C0_CLK];
            end
            if (wr_ctrl1) begin
                cfg_ff.pcfg       <= wb_dat_i[`ADCS_C1_PCFG];
                cfg_ff.clk_sel[2] <= wb_dat_i[`ADCS_C1_CLK2];
                cfg_ff.justify    <= wb_dat_i[`ADCS_C1_JUST];
            end
        end
    end

    // Compare unit two mode field, mirrored here to qualify the trigger
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_mode_ff <= `ADCS_RST_MODE;
        end else if (wr_en && wb_adr_i == `ADCS_IDX_COMPARE) begin
            compare_mode_ff <= wb_dat_i[`ADCS_CMP_MODE];
        end
    end

    // ****************************************************************
    // Go flag and trigger
    // ****************************************************************

    assign trig_hit = special_trig_i && (compare_mode_ff == `ADCS_SPECIAL);

    // Go is gated by the power bit as it stood before the write, so a
    // write that powers up and sets go together starts nothing
    assign go_set = power_on_ff & ((wr_ctrl0 & wb_dat_i[`ADCS_C0_GO])
                                   | trig_hit);
    assign go_clr = sar_done
                  | (wr_ctrl0 & ~wb_dat_i[`ADCS_C0_GO])
                  | (wr_ctrl0 & ~wb_dat_i[`ADCS_C0_PWR]);

    // A new start beats a completion or a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_ff <= 1'b0;
        end else if (go_set) begin
            go_ff <= 1'b1;
        end else if (go_clr) begin
            go_ff <= 1'b0;
        end
    end

    // Timer reset follows every special event, powered or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_reset_o <= 1'b0;
        end else begin
            timer_reset_o <= trig_hit;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Channel and direction bits play no part in the start condition
    assign conv_start = (state_ff == adcs_pkg::ADCS_ACQ) & go_ff
                        & power_on_ff;
    assign conv_abort = (state_ff == adcs_pkg::ADCS_CONV) & ~go_ff
                        & ~sar_done;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            adcs_pkg::ADCS_ACQ: begin
                if (conv_start) begin
                    nxt_state = adcs_pkg::ADCS_CONV;
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (sar_done) begin
                    nxt_state = adcs_pkg::ADCS_ACQ;
                end else if (conv_abort) begin
                    nxt_state = adcs_pkg::ADCS_WAIT;
                end
            end
            adcs_pkg::ADCS_WAIT: begin
                if (tad_tick && wait_cnt_ff == `ADCS_ABORT_TADS - 2'h1) begin
                    nxt_state = adcs_pkg::ADCS_ACQ;
                end
            end
            default: nxt_state = adcs_pkg::ADCS_ACQ;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= adcs_pkg::ADCS_ACQ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counts bit periods spent in the post-abort wait
    always_ff @(posedge clk_i) begin
        if (rst_i || state_ff != adcs_pkg::ADCS_WAIT) begin
            wait_cnt_ff <= '0;
        end else if (tad_tick) begin
            wait_cnt_ff <= wait_cnt_ff + 2'h1;
        end
    end

    // Hold capacitor tracks the pin only while acquiring
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_connect_o <= 1'b1;
        end else begin
            hold_connect_o <= (nxt_state == adcs_pkg::ADCS_ACQ);
        end
    end

    // Channel goes straight to the mux, whatever the pin setup
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_o <= '0;
        end else begin
            channel_o <= cfg_ff.channel;
        end
    end

    // ****************************************************************
    // Results and status
    // ****************************************************************

    // Completion loads the justified result; an abort never reaches here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_high_ff <= `ADCS_RST_BYTE;
            result_low_ff  <= `ADCS_RST_BYTE;
        end else if (sar_done) begin
            if (cfg_ff.justify) begin
                result_high_ff <= {6'h00, sar_code[9:8]};
                result_low_ff  <= sar_code[7:0];
            end else begin
                result_high_ff <= sar_code[9:2];
                result_low_ff  <= {sar_code[1:0], 6'h00};
            end
        end else if (wr_en) begin
            if (wb_adr_i == `ADCS_IDX_RES_HI) begin
                result_high_ff <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `ADCS_IDX_RES_LO) begin
                result_low_ff <= wb_dat_i[7:0];
            end
        end
    end

    // Done flag, write one to clear; a completion wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_flag_ff <= 1'b0;
        end else if (sar_done) begin
            done_flag_ff <= 1'b1;
        end else if (wr_en && wb_adr_i == `ADCS_IDX_STATUS
                     && wb_dat_i[`ADCS_ST_DONE]) begin
            done_flag_ff <= 1'b0;
        end
    end

    // Port pins are asynchronous, so two flops before the read mux
    always_ff @(posedge clk_i) begin
        pin_meta_ff <= port_pins_i;
        pin_sync_ff <= pin_meta_ff;
    end

    // DAC trial code leaves through a flop inside the converter core
    assign dac_code_o = sar_code;

    // ****************************************************************
    // Submodules
    // ****************************************************************

    // Ticks run outside acquisition; any state change restarts the divider,
    // so with a divided clock the post-abort wait gets two whole bit periods
    adcs_tad_gen #(
        .DIV_W    (DIV_W)
    ) u_tad (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    ((state_ff != adcs_pkg::ADCS_ACQ) && (nxt_state == state_ff)),
        .sel_i    (cfg_ff.clk_sel),
        .rc_osc_i (rc_osc_i),
        .tick_o   (tad_tick)
    );

    // Successive-approximation core
    adcs_sar #(
        .WIDTH    (WIDTH)
    ) u_sar (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (conv_start),
        .abort_i  (conv_abort),
        .tick_i   (tad_tick),
        .comp_i   (comp_i),
        .code_o   (sar_code),
        .done_o   (sar_done)
    );

endmodule

// [hw/adcs_defines.svh]
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// Register word indices (byte address = 4 * index)
`define ADCS_IDX_CTRL0   3'h0
`define ADCS_IDX_CTRL1   3'h1
`define ADCS_IDX_RES_HI  3'h2
`define ADCS_IDX_RES_LO  3'h3
`define ADCS_IDX_STATUS  3'h4
`define ADCS_IDX_PORT    3'h5
`define ADCS_IDX_COMPARE 3'h6

// Field positions
`define ADCS_C0_PWR   0
`define ADCS_C0_GO    2
`define ADCS_C0_CHAN  5:3
`define ADCS_C0_CLK   7:6
`define ADCS_C1_PCFG  3:0
`define ADCS_C1_CLK2  6
`define ADCS_C1_JUST  7
`define ADCS_ST_DONE  0
`define ADCS_CMP_MODE 3:0

// Reset values
`define ADCS_RST_CFG  11'h000
`define ADCS_RST_MODE 4'h0
`define ADCS_RST_BYTE 8'h00

// Timing and codes
`define ADCS_CONV_TADS  4'hc
`define ADCS_ABORT_TADS 2'h2
`define ADCS_SPECIAL    4'hb
`define ADCS_RC_SEL     2'h3
`define ADCS_MIN_DIV_W  7

`endif

// [hw/adcs_pkg.sv]
package adcs_pkg;

    // Sequencer states, Gray along acquire -> convert -> abort wait
    typedef enum logic [1:0] {
        ADCS_ACQ  = 2'h0,
        ADCS_CONV = 2'h1,
        ADCS_WAIT = 2'h3
    } adcs_state_t;

    // Software configuration carried as one word
    typedef struct packed {
        logic       justify;
        logic [2:0] clk_sel;
        logic [2:0] channel;
        logic [3:0] pcfg;
    } adcs_cfg_t;

endpackage

// [hw/adcs_tad_gen.sv]
`timescale 1ns/10ps
`include "adcs_defines.svh"

module adcs_tad_gen #(
    parameter int DIV_W = 7
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    input  wire logic       rc_osc_i,
    output logic            tick_o
);

    if (DIV_W < `ADCS_MIN_DIV_W) begin : g_chk
        $error("adcs_tad_gen: DIV_W too small for 64 clocks");
    end

    logic [DIV_W-1:0] cnt_ff;
    logic             rc_meta_ff;
    logic             rc_sync_ff;
    logic             rc_last_ff;
    logic             is_rc;

    // Divide ratio 2 << {sel[1:0], sel[2]}, minus one for the terminal count
    function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] sel);
        div_limit = DIV_W'((7'h02 << {sel[1:0], sel[2]}) - 7'h01);
    endfunction

    assign is_rc = (sel_i[1:0] == `ADCS_RC_SEL);

    // RC clock crosses through two flops; the second and a delayed copy of it are looked at
    always_ff @(posedge clk_i) begin
        rc_meta_ff <= rc_osc_i;
        rc_sync_ff <= rc_meta_ff;
        rc_last_ff <= rc_sync_ff;
    end

    // Oscillator divider, held in reset so each conversion starts aligned
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || cnt_ff == div_limit(sel_i)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // One tick per bit period, from the divider or a synced RC rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else if (is_rc) begin
            tick_o <= run_i & rc_sync_ff & ~rc_last_ff;
        end else begin
            tick_o <= run_i & (cnt_ff == div_limit(sel_i));
        end
    end

endmodule

// [hw/adcs_sar.sv]
`timescale 1ns/10ps
`include "adcs_defines.svh"

module adcs_sar #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             start_i,
    input  wire logic             abort_i,
    input  wire logic             tick_i,
    input  wire logic             comp_i,
    output logic [WIDTH-1:0]      code_o,
    output logic                  done_o
);

    if (WIDTH + 2 != int'(`ADCS_CONV_TADS)) begin : g_chk
        $error("adcs_sar: WIDTH must match the bit-period count");
    end

    logic [3:0]       tad_ff;
    logic [WIDTH-1:0] trial_ff;
    logic             busy_ff;
    logic             comp_meta_ff;
    logic             comp_sync_ff;

    // Comparator is asynchronous, so two flops; this costs two clocks,
    // and a bit period of two clocks decides on the previous trial
    always_ff @(posedge clk_i) begin
        comp_meta_ff <= comp_i;
        comp_sync_ff <= comp_meta_ff;
    end

    // Bit period 0 settles, 1..WIDTH decide bits, last one completes
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i || abort_i) begin
            busy_ff  <= 1'b0;
            tad_ff   <= '0;
            trial_ff <= '0;
            code_o   <= '0;
        end else if (start_i) begin
            busy_ff <= 1'b1;
            tad_ff  <= '0;
            code_o  <= '0;
        end else if (busy_ff && tick_i) begin
            tad_ff <= tad_ff + 4'h1;
            if (tad_ff == 4'h0) begin
                code_o   <= {1'b1, {(WIDTH-1){1'b0}}};
                trial_ff <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (tad_ff <= 4'(WIDTH)) begin
                code_o   <= (comp_sync_ff ? code_o : (code_o & ~trial_ff))
                            | (trial_ff >> 1);
                trial_ff <= trial_ff >> 1;
            end else if (tad_ff == `ADCS_CONV_TADS - 4'h1) begin
                busy_ff <= 1'b0;
                done_o  <= 1'b1;
            end
        end
    end

endmodule

// [verif/adcs_top_chk.sv]
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module adcs_top_chk #(
    parameter int WIDTH = 10,
    parameter int DIV_W = 7
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        special_trig_i,
    input wire logic        hold_connect_o,
    input wire logic [9:0]  dac_code_o,
    input wire logic        timer_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Bus answers once, one cycle after the request is taken
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // Timer reset only follows a trigger pulse
    a_timer_cause: assert property (timer_reset_o |-> $past(special_trig_i))
        else $error("timer reset without trigger");
    a_timer_pulse: assert property (timer_reset_o |=> !timer_reset_o)
        else $error("timer reset longer than one cycle");
    // Hold cap stays off for at least four clocks, and comes back
    a_hold_low: assert property ($fell(hold_connect_o) |-> !hold_connect_o [*4])
        else $error("hold cap reconnected too soon");
    a_hold_return: assert property ($fell(hold_connect_o) |-> ##[4:1000] hold_connect_o)
        else $error("hold cap never reconnected");
    // Trial codes only change to a nonzero value while the cap is isolated
    a_dac_hold: assert property ($changed(dac_code_o) && dac_code_o != 10'h0
        |-> !$past(hold_connect_o))
        else $error("trial code moved while sampling");
    a_rst_state: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && hold_connect_o
        && !timer_reset_o && dac_code_o == 10'h0)
        else $error("outputs not at reset state");
endmodule

// [verif/adcs_analog_model.sv]
`timescale 1ns/10ps
// ****************
// Analog far side
// ****************
module adcs_analog_model (
    input  wire logic       clk_i,
    input  wire logic       hold_connect_i,
    input  wire logic [9:0] dac_code_i,
    input  wire logic [9:0] level_i,
    output logic            comp_o,
    output logic            rc_osc_o,
    output logic [7:0]      pins_o
);
    logic [9:0] held_ff;

    // Cap tracks the pin only while connected
    always_ff @(posedge clk_i) begin
        if (hold_connect_i) begin
            held_ff <= level_i;
        end
    end

    // Comparator sees the held charge, so a moving pin cannot skew a result
    assign comp_o = (held_ff >= dac_code_i);
    assign pins_o = 8'h5c;

    // Free-running RC source, unrelated in phase to the system clock
    initial begin
        rc_osc_o = 1'b0;
        forever #17 rc_osc_o = ~rc_osc_o;
    end
endmodule

// [verif/tb_adcs_top.sv]
`timescale 1ns/10ps
module tb_adcs_top;
    logic        clk_i, rst_i, cyc, stb, we, trig;
    logic [2:0]  adr;
    logic [7:0]  wdat;
    logic [31:0] rdat, wb_dat_o;
    logic [9:0]  level, dac;
    logic        wb_ack_o, comp, rc, hold_connect_o, timer_reset_o;
    logic [7:0]  pins;
    logic [2:0]  chan;
    int          n_fail, n_tests, tmo, lowcnt, lastlow, n_tmr, k;
    logic [2:0]  codes [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
    int          ndiv [6] = '{2, 4, 8, 16, 32, 64};
    logic [2:0]  ridx [5] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7};

    adcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wdat}),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_osc_i(rc), .comp_i(comp),
        .port_pins_i(pins), .special_trig_i(trig), .channel_o(chan),
        .hold_connect_o(hold_connect_o), .dac_code_o(dac), .timer_reset_o(timer_reset_o));

    adcs_analog_model i_far (.clk_i(clk_i), .hold_connect_i(hold_connect_o),
        .dac_code_i(dac), .level_i(level), .comp_o(comp), .rc_osc_o(rc), .pins_o(pins));

    // ****************
    // Clock, monitors
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Length of each isolation window, timer pulses, and a hang guard
    always @(posedge clk_i) begin
        lowcnt <= hold_connect_o ? 0 : lowcnt + 1;
        if (hold_connect_o && lowcnt != 0) lastlow <= lowcnt;
        if (timer_reset_o) n_tmr <= n_tmr + 1;
        tmo <= tmo + 1;
        if (tmo == 30000) begin
            n_fail++;
            tally_and_finish;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; request held until ack is seen
    task xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task rdchk(input logic [2:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        check(rdat, {24'h0, exp});
    endtask

    // Poll the done flag; bounded so a lost completion cannot hang
    task wait_done;
        for (int i = 0; i < 700; i++) begin
            xfer(1'b0, 3'h4, 8'h00);
            if (rdat[0] === 1'b1) break;
        end
        check(32'(rdat[0]), 32'h1);
    endtask

    task pulse;
        @(posedge clk_i);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
    endtask

    task conv(input logic [2:0] c, input logic j, input logic [3:0] pc, input logic [9:0] v);
        level <= v;
        xfer(1'b1, 3'h1, {j, c[2], 2'b00, pc});
        xfer(1'b1, 3'h0, {c[1:0], 3'h3, 3'b001});
        repeat (40) @(posedge clk_i);
        xfer(1'b1, 3'h0, {c[1:0], 3'h3, 3'b101});
        wait_done;
        check(32'(chan), 32'h3);
        rdchk(3'h2, j ? {6'h0, v[9:8]} : v[9:2]);
        rdchk(3'h3, j ? v[7:0] : {v[1:0], 6'h0});
        rdchk(3'h0, {c[1:0], 3'h3, 3'b001});
        xfer(1'b1, 3'h4, 8'h01);
    endtask

    task tally_and_finish;
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************
    // Sequence
    // ****************
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, trig, adr, wdat, level} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 5; k++) rdchk(ridx[k], 8'h00);
        // Every divided clock, both justifications; full scale on the
        // two-clock period, whose decisions see the previous trial
        for (k = 0; k < 6; k++) begin
            conv(codes[k], k[0], 4'h0, 10'h3ff - 10'(k * 195));
            check(32'(lastlow >= 12 * ndiv[k] && lastlow <= 12 * ndiv[k] + 3), 32'h1);
        end
        // RC clock on a digital-configured pin; port reads
        conv(3'b011, 1'b1, 4'h6, 10'h3c1);
        rdchk(3'h5, 8'h5c);
        xfer(1'b1, 3'h1, 8'h80);
        rdchk(3'h5, 8'h00);
        // Abort keeps software-written results
        xfer(1'b1, 3'h2, 8'h3c);
        xfer(1'b1, 3'h3, 8'hc3);
        xfer(1'b1, 3'h0, 8'h81);
        xfer(1'b1, 3'h0, 8'h85);
        repeat (60) @(posedge clk_i);
        xfer(1'b1, 3'h0, 8'h81);
        repeat (40) @(posedge clk_i);
        check(32'(hold_connect_o), 32'h0);
        repeat (40) @(posedge clk_i);
        check(32'(hold_connect_o), 32'h1);
        rdchk(3'h2, 8'h3c);
        rdchk(3'h3, 8'hc3);
        rdchk(3'h4, 8'h00);
        // Compare trigger, powered then unpowered
        xfer(1'b1, 3'h6, 8'h0b);
        xfer(1'b1, 3'h0, 8'h41);
        level <= 10'h155;
        repeat (40) @(posedge clk_i);
        pulse;
        wait_done;
        check(n_tmr, 1);
        rdchk(3'h3, 8'h55);
        xfer(1'b1, 3'h4, 8'h01);
        xfer(1'b1, 3'h0, 8'h00);
        pulse;
        repeat (60) @(posedge clk_i);
        check(n_tmr, 2);
        rdchk(3'h4, 8'h00);
        // Reset in mid-conversion
        xfer(1'b1, 3'h0, 8'h01);
        xfer(1'b1, 3'h0, 8'h05);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(3'h0, 8'h00);
        check(32'(hold_connect_o), 32'h1);
        tally_and_finish;
    end
endmodule

bind adcs_top adcs_top_chk #(.WIDTH(WIDTH), .DIV_W(DIV_W)) i_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .special_trig_i(special_trig_i), .hold_connect_o(hold_connect_o),
    .dac_code_o(dac_code_o), .timer_reset_o(timer_reset_o));
